// ==== rtl/i2c_target.sv ====
`timescale 1ns/1ps
`include "i2c_target_cfg.svh"

// ****************************************************************
// Receive FIFO
// ****************************************************************
// DEPTH must be a power of two; the extra pointer bit tells full from empty.
module rx_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 16,
	parameter int AW = $clog2(DEPTH)
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Filling side
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	// Draining side
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	logic [W-1:0] mem [DEPTH];
	logic [AW:0] wr_reg;
	logic [AW:0] rd_reg;

	assign in_ready = !((wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]));
	assign out_valid = (wr_reg != rd_reg);
	assign out_data = mem[rd_reg[AW-1:0]];

	always_ff @(posedge clk_sys) begin
		if (in_valid && in_ready) begin
			mem[wr_reg[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			wr_reg <= '0;
			rd_reg <= '0;
		end else begin
			if (in_valid && in_ready) begin
				wr_reg <= wr_reg + 1'b1;
			end
			if (out_valid && out_ready) begin
				rd_reg <= rd_reg + 1'b1;
			end
		end
	end
endmodule

// ****************************************************************
// I2C target with acknowledge window and hold control
// ****************************************************************
module i2c_target #(
	parameter int FIFO_DEPTH = `RX_FIFO_DEPTH
) (
	// System clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Link sampling clock
	input wire logic link_clk,
	// Bus pins, open drain
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Control
	input wire logic module_en,
	input wire logic cpu_idle,
	input wire logic scl_release,
	input wire logic bcl_clear,
	input wire i2c_target_pkg::cfg_t cfg,
	// Status
	output logic ack_window_flag,
	output logic bus_collision_flag,
	output logic target_irq,
	// Received bytes
	output logic rx_buffer_full,
	output logic [7:0] rx_data,
	input wire logic rx_ready
);
	import i2c_target_pkg::*;

	localparam int CW = $bits(cfg_t);
	localparam int XW = CW + 4;

	// ****************************************************************
	// System domain: control capture
	// ****************************************************************
	cfg_t cfg_reg;
	logic run_reg;
	logic idle_stop_reg;
	logic rel_tgl_reg;
	logic rst_hold_reg;

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			cfg_reg <= '0;
			run_reg <= 1'b0;
			idle_stop_reg <= 1'b0;
			rel_tgl_reg <= 1'b0;
			rst_hold_reg <= 1'b0;
		end else begin
			cfg_reg <= cfg;
			run_reg <= module_en;
			idle_stop_reg <= cfg.stop_in_idle && cpu_idle; // see RULE10
			rst_hold_reg <= 1'b1;
			if (scl_release) begin
				rel_tgl_reg <= !rel_tgl_reg;
			end
		end
	end

	// ****************************************************************
	// Crossing into the link domain
	// ****************************************************************
	// Configuration is quasi-static: software changes it only while the module is off.
	logic [XW-1:0] s2l_meta;
	logic [XW-1:0] s2l_sync;
	logic ack_tgl_reg;
	logic ack_meta;
	logic ack_sync;

	always_ff @(posedge link_clk) begin
		s2l_meta <= {rst_hold_reg, run_reg, idle_stop_reg, rel_tgl_reg, cfg_reg};
		s2l_sync <= s2l_meta;
		ack_meta <= ack_tgl_reg;
		ack_sync <= ack_meta;
	end

	cfg_t lcfg;
	logic lrst_ok;
	logic lrun;
	logic lidle;
	logic lrel;
	assign {lrst_ok, lrun, lidle, lrel, lcfg} = s2l_sync;

	// ****************************************************************
	// Link domain: pin sampling and bus conditions
	// ****************************************************************
	logic [1:0] pin_meta;
	logic [1:0] pin_sync;
	logic [1:0] pin_d;

	always_ff @(posedge link_clk) begin
		pin_meta <= {scl_in, sda_in};
		pin_sync <= pin_meta;
		pin_d <= pin_sync;
	end

	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	assign scl_rise = pin_sync[1] && !pin_d[1];
	assign scl_fall = !pin_sync[1] && pin_d[1];
	assign start_cond = pin_sync[1] && pin_d[1] && pin_d[0] && !pin_sync[0];
	assign stop_cond = pin_sync[1] && pin_d[1] && !pin_d[0] && pin_sync[0];

	// ****************************************************************
	// Link domain: byte engine
	// ****************************************************************
	link_state_t state_reg;
	phase_t phase_reg;
	logic [3:0] bitcnt_reg;
	logic [7:0] shift_reg;
	logic ack_win_reg;
	logic sw_hold_reg;
	logic push_tgl_reg;
	logic [7:0] push_data_reg;
	logic coll_tgl_reg;
	logic evt_tgl_reg;
	logic rel_d_reg;

	logic hit;
	logic push_busy;
	logic rel_evt;
	logic mid_byte;
	assign push_busy = (push_tgl_reg != ack_sync);
	assign rel_evt = (lrel != rel_d_reg);
	// A Stop or repeated Start that closes a frame follows one sampled SCL rise, so one bit is normal.
	assign mid_byte = (state_reg == RX_BYTE) && (bitcnt_reg > 4'h1);

	always_comb begin
		case (phase_reg)
			PH_ADDR: begin
				if (lcfg.ten_bit_en) begin
					hit = (shift_reg[7:3] == `TEN_BIT_PREFIX) &&
						(shift_reg[2:1] == lcfg.own_addr[9:8]) && !shift_reg[0];
				end else begin
					hit = (shift_reg[7:1] == lcfg.own_addr[6:0]) && !shift_reg[0];
				end
			end
			PH_ADDR_LO: begin
				hit = (shift_reg == lcfg.own_addr[7:0]);
			end
			default: begin
				hit = 1'b1;
			end
		endcase
	end

	always_ff @(posedge link_clk) begin
		rel_d_reg <= lrel;
	end

	// Toggles live only under the system reset so a module disable cannot fake an event.
	always_ff @(posedge link_clk) begin
		if (!lrst_ok) begin
			push_tgl_reg <= 1'b0;
			push_data_reg <= 8'h00;
			coll_tgl_reg <= 1'b0;
			evt_tgl_reg <= 1'b0;
		end else if (lrun && !lidle) begin
			if ((start_cond || stop_cond) && mid_byte && lcfg.target_collision_detect_en) begin
				coll_tgl_reg <= !coll_tgl_reg; // see RULE11
			end
			if (state_reg == RX_BYTE && scl_fall && bitcnt_reg == `BITS_PER_BYTE && hit &&
				phase_reg == PH_DATA && lcfg.data_hold_en) begin
				evt_tgl_reg <= !evt_tgl_reg; // see RULE12
			end
			if (state_reg == STRETCH && !push_busy && (rel_evt || !sw_hold_reg) &&
				phase_reg == PH_DATA) begin
				push_data_reg <= shift_reg;
				push_tgl_reg <= !push_tgl_reg;
			end
		end
	end

	always_ff @(posedge link_clk) begin
		if (!lrun || lidle) begin // see RULE10
			state_reg <= IDLE;
			phase_reg <= PH_ADDR;
			bitcnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			ack_win_reg <= 1'b0;
			sw_hold_reg <= 1'b0;
		end else if (start_cond) begin
			state_reg <= RX_BYTE;
			phase_reg <= PH_ADDR;
			bitcnt_reg <= 4'h0;
			ack_win_reg <= 1'b0;
		end else if (stop_cond) begin
			state_reg <= IDLE;
			ack_win_reg <= 1'b0;
		end else begin
			case (state_reg)
				RX_BYTE: begin
					if (scl_rise && bitcnt_reg != `BITS_PER_BYTE) begin
						shift_reg <= {shift_reg[6:0], pin_sync[0]};
						bitcnt_reg <= bitcnt_reg + 4'h1;
					end else if (scl_fall && bitcnt_reg == `BITS_PER_BYTE) begin
						if (!hit) begin
							state_reg <= SKIP;
						end else begin
							state_reg <= STRETCH;
							// The upper ten-bit byte takes the same path. see RULE4
							ack_win_reg <= lcfg.address_hold_en || lcfg.data_hold_en; // see RULE1, RULE5
							if (phase_reg == PH_DATA) begin
								sw_hold_reg <= lcfg.data_hold_en;
							end else begin
								sw_hold_reg <= lcfg.address_hold_en; // see RULE2, RULE3
							end
						end
					end
				end
				STRETCH: begin
					if (!push_busy && (rel_evt || !sw_hold_reg)) begin // see RULE2
						state_reg <= ACK_BIT;
						if (phase_reg == PH_ADDR && lcfg.ten_bit_en) begin
							phase_reg <= PH_ADDR_LO;
						end else begin
							phase_reg <= PH_DATA;
						end
					end
				end
				ACK_BIT: begin
					if (scl_rise) begin
						ack_win_reg <= 1'b0; // see RULE1
					end else if (scl_fall) begin
						bitcnt_reg <= 4'h0;
						state_reg <= lcfg.ack_value_bit ? SKIP : RX_BYTE;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ****************************************************************
	// Link domain: pin drivers with hold and setup timing
	// ****************************************************************
	logic [7:0] hold_cnt_reg;
	logic [7:0] setup_cnt_reg;
	logic want_low;
	assign want_low = (state_reg == ACK_BIT) && !lcfg.ack_value_bit; // see RULE14

	always_ff @(posedge link_clk) begin
		if (!lrun || lidle) begin
			hold_cnt_reg <= 8'h00;
			setup_cnt_reg <= 8'h00;
			sda_oe <= 1'b0;
			scl_oe <= 1'b0;
		end else begin
			if (scl_fall) begin
				hold_cnt_reg <= lcfg.sda_hold_select ? 8'(`HOLD_LONG_CYC) :
					8'(`HOLD_SHORT_CYC); // see RULE9
			end else if (hold_cnt_reg != 8'h00) begin
				hold_cnt_reg <= hold_cnt_reg - 8'h01;
			end
			if (state_reg == STRETCH) begin
				setup_cnt_reg <= 8'(`SETUP_CYC);
			end else if (setup_cnt_reg != 8'h00) begin
				setup_cnt_reg <= setup_cnt_reg - 8'h01;
			end
			// SDA may only change once the hold time after the last SCL fall has run out.
			if (hold_cnt_reg == 8'h00 && !scl_fall) begin
				sda_oe <= want_low; // see RULE9, RULE14
			end
			scl_oe <= (state_reg == STRETCH) ||
				(state_reg == ACK_BIT && setup_cnt_reg > 8'h01); // see RULE2
		end
	end

	always_ff @(posedge link_clk) begin
		scl_out <= 1'b0;
		sda_out <= 1'b0;
	end

	// ****************************************************************
	// Crossing back into the system domain
	// ****************************************************************
	logic [3:0] l2s_meta;
	logic [3:0] l2s_sync;
	logic [2:0] l2s_d;

	always_ff @(posedge clk_sys) begin
		l2s_meta <= {ack_win_reg, coll_tgl_reg, evt_tgl_reg, push_tgl_reg};
		l2s_sync <= l2s_meta;
	end

	assign ack_window_flag = l2s_sync[3];

	logic pend_reg;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [7:0] fifo_out_data;
	logic fifo_out_ready;

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			l2s_d <= 3'h0;
			pend_reg <= 1'b0;
			ack_tgl_reg <= 1'b0;
			target_irq <= 1'b0;
			bus_collision_flag <= 1'b0;
		end else begin
			l2s_d <= l2s_sync[2:0];
			target_irq <= (l2s_sync[1] != l2s_d[1]); // see RULE12
			if (l2s_sync[2] != l2s_d[2]) begin
				bus_collision_flag <= 1'b1; // see RULE11
			end else if (bcl_clear || !run_reg) begin
				bus_collision_flag <= 1'b0; // see RULE8
			end
			// The link side holds its byte until this handshake closes and, while it is open, stretches SCL in the next byte's STRETCH state.
			if (l2s_sync[0] != l2s_d[0]) begin
				pend_reg <= 1'b1;
			end else if (pend_reg && fifo_in_ready) begin
				pend_reg <= 1'b0;
				ack_tgl_reg <= !ack_tgl_reg;
			end
		end
	end

	rx_fifo #(
		.W(8),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.in_valid(pend_reg),
		.in_data(push_data_reg),
		.in_ready(fifo_in_ready),
		.out_valid(fifo_out_valid),
		.out_data(fifo_out_data),
		.out_ready(fifo_out_ready)
	);

	// ****************************************************************
	// Output stage
	// ****************************************************************
	assign fifo_out_ready = !rx_buffer_full || rx_ready;

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			rx_buffer_full <= 1'b0;
			rx_data <= 8'h00;
		end else if (fifo_out_ready) begin
			rx_buffer_full <= fifo_out_valid;
			rx_data <= fifo_out_data;
		end
	end
endmodule

// ==== rtl/i2c_target_cfg.svh ====
`ifndef I2C_TARGET_CFG_SVH
`define I2C_TARGET_CFG_SVH
// Notes on behaviour
// RULE1: The acknowledge-window flag rises on the falling SCL edge that ends bit eight and drops on the rising SCL edge of bit nine.
// RULE2: With address hold on, SCL is held low after the eighth falling edge and the flag stays up until software releases the clock.
// RULE3: With address hold off, SCL is not held for address bytes and the flag lasts only the short acknowledge bit.
// RULE4: In ten-bit addressing the flag is raised for the upper address byte just as for the lower byte and data bytes.
// RULE5: While receiving, the flag is raised only when address hold or data hold is on, and stays clear with both off.
// RULE6: Software detects each received byte by the receive-buffer-full flag, not by the acknowledge-window flag.
// RULE7: With address hold on, software tracks phases itself and answers NACK to foreign bytes until a Stop.
// RULE8: Switching the module off and on again clears the bus-collision flag, even with collision detection on.
// RULE9: With the hold select bit set, SDA is held at least 300 ns after each falling SCL edge.
// RULE10: With stop-in-idle set and the CPU in Idle, the target logic stops and takes no address.
// RULE11: With collision detection on, only real collisions (Start or Stop inside a byte) raise the collision flag.
// RULE12: With data hold on, a target event pulse follows the eighth clock of each received data byte.
// RULE13: Software clears the acknowledge value bit on each Start so that hold stretching and events work.
// RULE14: During the ninth clock SDA is driven low for ACK when the acknowledge value bit is clear, released for NACK.

// ****************************************************************
// Timing
// ****************************************************************
`define LINK_CLK_NS 12
`define HOLD_LONG_NS 300
`define HOLD_SHORT_NS 100
`define SETUP_NS 250
`define HOLD_LONG_CYC ((`HOLD_LONG_NS + `LINK_CLK_NS - 1) / `LINK_CLK_NS)
`define HOLD_SHORT_CYC ((`HOLD_SHORT_NS + `LINK_CLK_NS - 1) / `LINK_CLK_NS)
`define SETUP_CYC ((`SETUP_NS + `LINK_CLK_NS - 1) / `LINK_CLK_NS)

// ****************************************************************
// Bus encodings
// ****************************************************************
`define TEN_BIT_PREFIX 5'h1e
`define BITS_PER_BYTE 4'h8
`define RX_FIFO_DEPTH 16
`endif

// ==== rtl/i2c_target_pkg.sv ====
package i2c_target_pkg;
	typedef struct packed {
		logic address_hold_en;
		logic data_hold_en;
		logic ack_value_bit;
		logic target_collision_detect_en;
		logic sda_hold_select;
		logic stop_in_idle;
		logic ten_bit_en;
		logic [9:0] own_addr;
	} cfg_t;

	typedef enum logic [2:0] {IDLE, RX_BYTE, STRETCH, ACK_BIT, SKIP} link_state_t;

	typedef enum logic [1:0] {PH_ADDR, PH_ADDR_LO, PH_DATA} phase_t;
endpackage

// ==== dv/i2c_target_sva.sv ====
`timescale 1ns/1ps
`include "i2c_target_cfg.svh"

// ****************************************************************
// Port checker
// ****************************************************************
module i2c_target_sva (
	// Clocks and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic link_clk,
	// Bus
	input wire logic scl_in,
	input wire logic scl_oe,
	input wire logic sda_oe,
	// Control
	input wire logic module_en,
	input wire logic cpu_idle,
	input wire i2c_target_pkg::cfg_t cfg,
	// Status
	input wire logic ack_window_flag,
	input wire logic bus_collision_flag,
	input wire logic target_irq,
	input wire logic rx_buffer_full
);
	import i2c_target_pkg::*;
	logic scl_q;
	logic [7:0] low_cnt;
	logic [7:0] fall_cnt;
	always_ff @(posedge link_clk) begin
		scl_q <= scl_in;
	end
	// Both counters saturate so that a long stall never wraps back into range.
	always_ff @(posedge link_clk) begin
		low_cnt <= !scl_oe ? 8'h00 : (low_cnt == 8'hff) ? low_cnt : low_cnt + 8'h01;
	end
	always_ff @(posedge link_clk) begin
		fall_cnt <= (scl_q && !scl_in) ? 8'h01 : (fall_cnt == 8'hff) ? fall_cnt : fall_cnt + 8'h01;
	end
	sequence s_rel_long;
		$fell(sda_oe) ##0 cfg.sda_hold_select;
	endsequence
	sequence s_rel_short;
		$fell(sda_oe) ##0 !cfg.sda_hold_select;
	endsequence
	hold_long_a:
		assert property (@(posedge link_clk) disable iff (!rst_b || !module_en)
		s_rel_long |-> fall_cnt >= `HOLD_LONG_CYC) else $error("sda released before long hold");
	hold_short_a:
		assert property (@(posedge link_clk) disable iff (!rst_b || !module_en)
		s_rel_short |-> fall_cnt >= `HOLD_SHORT_CYC) else $error("sda released too soon");
	ack_level_a:
		assert property (@(posedge link_clk) disable iff (!rst_b || !module_en)
		sda_oe |-> !cfg.ack_value_bit) else $error("sda pulled low for a nack");
	no_stretch_a:
		assert property (@(posedge link_clk) disable iff (!rst_b || !module_en)
		low_cnt >= 8'h28 |-> cfg.address_hold_en || cfg.data_hold_en || rx_buffer_full)
		else $error("scl stretched without hold");
	idle_quiet_a:
		assert property (@(posedge link_clk) disable iff (!rst_b)
		(cpu_idle && cfg.stop_in_idle) [*8] |-> !scl_oe && !sda_oe)
		else $error("bus driven while stopped in idle");
	flag_cause_a:
		assert property (@(posedge clk_sys) disable iff (!rst_b || !module_en)
		ack_window_flag |-> cfg.address_hold_en || cfg.data_hold_en) else $error("flag without hold");
	flag_rise_a:
		assert property (@(posedge clk_sys) disable iff (!rst_b || !module_en)
		$rose(ack_window_flag) |-> !scl_in) else $error("flag rose with scl high");
	flag_drop_a:
		assert property (@(posedge clk_sys) disable iff (!rst_b || !module_en)
		$fell(ack_window_flag) |-> scl_in) else $error("flag fell with scl low");
	event_flag_a:
		assert property (@(posedge clk_sys) disable iff (!rst_b || !module_en)
		target_irq |-> cfg.data_hold_en ##[0:8] ack_window_flag) else $error("stray target event");
	coll_cause_a:
		assert property (@(posedge clk_sys) disable iff (!rst_b)
		$rose(bus_collision_flag) |-> cfg.target_collision_detect_en)
		else $error("collision flag while detection off");
	coll_clear_a:
		assert property (@(posedge clk_sys) disable iff (!rst_b)
		$fell(module_en) |-> ##[1:8] !bus_collision_flag) else $error("collision flag kept");
endmodule

bind i2c_target i2c_target_sva u_sva (
	.clk_sys(clk_sys),
	.rst_b(rst_b),
	.link_clk(link_clk),
	.scl_in(scl_in),
	.scl_oe(scl_oe),
	.sda_oe(sda_oe),
	.module_en(module_en),
	.cpu_idle(cpu_idle),
	.cfg(cfg),
	.ack_window_flag(ack_window_flag),
	.bus_collision_flag(bus_collision_flag),
	.target_irq(target_irq),
	.rx_buffer_full(rx_buffer_full)
);

// ==== dv/i2c_master_model.sv ====
`timescale 1ns/1ps

// ****************************************************************
// Bus controller model
// ****************************************************************
module i2c_master_model (
	// Clock
	input wire logic clk_sys,
	// Wires
	input wire logic scl,
	input wire logic sda,
	// Pull-downs and stall report
	output logic scl_low,
	output logic sda_low,
	output logic stuck
);
	localparam int Q = 25;
	logic got;
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
		stuck = 1'b0;
	end
	task automatic idle(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// The target may stretch the low phase, so the rise is awaited.
	task automatic rise();
		int k;
		scl_low = 1'b0;
		for (k = 0; k < 4000 && scl !== 1'b1; k++) idle(1);
		stuck = (scl !== 1'b1);
		got = sda;
		idle(Q);
	endtask
	task automatic start();
		sda_low = 1'b1;
		idle(Q);
		scl_low = 1'b1;
		idle(2);
	endtask
	// Data moves two cycles after the fall so that no edge reads as Start or Stop.
	task automatic bits(input logic [7:0] b, input int n);
		for (int i = 7; i > 7 - n; i--) begin
			sda_low = !b[i];
			idle(Q);
			rise();
			scl_low = 1'b1;
			idle(2);
		end
	endtask
	task automatic byte_tx(input logic [7:0] b, output logic ack);
		bits(b, 8);
		sda_low = 1'b0;
		idle(Q);
		rise();
		ack = got;
		scl_low = 1'b1;
		idle(2);
	endtask
	task automatic stop();
		sda_low = 1'b1;
		idle(Q);
		rise();
		sda_low = 1'b0;
		idle(Q);
	endtask
endmodule

// ==== dv/i2c_target_tb.sv ====
`timescale 1ns/1ps

// ****************************************************************
// Bench top
// ****************************************************************
module i2c_target_tb;
	import i2c_target_pkg::*;
	logic clk_sys, link_clk, rst_b, module_en, cpu_idle, scl_release, bcl_clear, rx_ready;
	logic scl_out, scl_oe, sda_out, sda_oe, m_scl, m_sda, stuck, flag_q, busy, ack;
	logic ack_window_flag, bus_collision_flag, target_irq, rx_buffer_full;
	logic [7:0] rx_data;
	cfg_t cfg;
	int n_fail = 0;
	int n_checks = 0;
	int n_flag, n_rel, n_irq;
	// Both lines have pull-ups; any party may pull low.
	wire scl_w = !(scl_oe || m_scl);
	wire sda_w = !(sda_oe || m_sda);
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	initial begin
		link_clk = 1'b0;
		#3;
		forever #6 link_clk = ~link_clk;
	end
	i2c_target u_dut (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.link_clk(link_clk),
		.scl_in(scl_w),
		.scl_out(scl_out),
		.scl_oe(scl_oe),
		.sda_in(sda_w),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.module_en(module_en),
		.cpu_idle(cpu_idle),
		.scl_release(scl_release),
		.bcl_clear(bcl_clear),
		.cfg(cfg),
		.ack_window_flag(ack_window_flag),
		.bus_collision_flag(bus_collision_flag),
		.target_irq(target_irq),
		.rx_buffer_full(rx_buffer_full),
		.rx_data(rx_data),
		.rx_ready(rx_ready)
	);
	i2c_master_model u_master (
		.clk_sys(clk_sys),
		.scl(scl_w),
		.sda(sda_w),
		.scl_low(m_scl),
		.sda_low(m_sda),
		.stuck(stuck)
	);
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	always @(posedge clk_sys) begin
		flag_q <= ack_window_flag;
		if (ack_window_flag === 1'b1 && flag_q === 1'b0) n_flag++;
		if (target_irq === 1'b1) n_irq++;
	end
	// Software side: a flag that still stands with SCL held is answered by a release.
	initial begin
		int k;
		forever begin
			@(negedge clk_sys);
			if (ack_window_flag === 1'b1) begin
				repeat (50) @(negedge clk_sys);
				if (ack_window_flag === 1'b1 && scl_w === 1'b0) begin
					n_rel++;
					scl_release = 1'b1;
					@(negedge clk_sys);
					scl_release = 1'b0;
				end
				for (k = 0; k < 3000 && ack_window_flag !== 1'b0; k++) @(negedge clk_sys);
			end
		end
	end
	always @(posedge stuck) begin
		$display("[ERR] scl expected high seen held low");
		n_fail++;
		end_of_test();
	end
	initial begin
		repeat (90000) @(posedge clk_sys);
		$display("[ERR] run expected done seen timeout");
		n_fail++;
		end_of_test();
	end
	// Mode bits run from address hold down to ten-bit enable, then the own address.
	task automatic setup(input cfg_t c);
		module_en = 1'b0;
		repeat (10) @(negedge clk_sys);
		// Configuration settles while the module is off, since it crosses bit by bit.
		cfg = c;
		n_flag = 0;
		n_rel = 0;
		n_irq = 0;
		repeat (4) @(negedge clk_sys);
		module_en = 1'b1;
		repeat (10) @(negedge clk_sys);
	endtask
	task automatic frame(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c,
			input logic [2:0] exp);
		logic a0, a1, a2;
		u_master.start();
		u_master.byte_tx(a, a0);
		u_master.byte_tx(b, a1);
		u_master.byte_tx(c, a2);
		u_master.stop();
		chk("acks", {5'h00, exp}, {5'h00, a0, a1, a2});
	endtask
	task automatic pop(input logic [7:0] exp);
		int k;
		for (k = 0; k < 3000 && rx_buffer_full !== 1'b1; k++) @(negedge clk_sys);
		if (rx_buffer_full !== 1'b1) begin
			$display("[ERR] rx_buffer_full expected 1 seen %b", rx_buffer_full);
			n_fail++;
			end_of_test();
		end
		chk("rx_data", exp, rx_data);
		rx_ready = 1'b1;
		@(negedge clk_sys);
		rx_ready = 1'b0;
		@(negedge clk_sys);
	endtask
	task automatic counts(input int f, input int r, input int q);
		chk("flags", f[7:0], n_flag[7:0]);
		chk("releases", r[7:0], n_rel[7:0]);
		chk("events", q[7:0], n_irq[7:0]);
	endtask
	task automatic coll(input logic exp);
		u_master.start();
		u_master.bits(8'ha0, 3);
		u_master.stop();
		chk("collision", {7'h00, exp}, {7'h00, bus_collision_flag});
	endtask
	initial begin
		int i, k, run;
		rst_b = 1'b0;
		module_en = 1'b0;
		cpu_idle = 1'b0;
		scl_release = 1'b0;
		bcl_clear = 1'b0;
		rx_ready = 1'b0;
		busy = 1'b0;
		run = 0;
		cfg = '0;
		repeat (10) @(negedge clk_sys);
		rst_b = 1'b1;
		setup({7'h64, 10'h02a});
		frame(8'h54, 8'h5a, 8'ha5, 3'b000);
		pop(8'h5a);
		pop(8'ha5);
		counts(3, 3, 2);
		$display("test hold done");
		setup({7'h00, 10'h02a});
		frame(8'h54, 8'h3c, 8'hc3, 3'b000);
		pop(8'h3c);
		pop(8'hc3);
		counts(0, 0, 0);
		$display("test plain done");
		setup({7'h41, 10'h2c5});
		frame(8'hf4, 8'hc5, 8'h96, 3'b000);
		pop(8'h96);
		counts(3, 2, 0);
		$display("test ten done");
		setup({7'h64, 10'h02a});
		frame(8'h56, 8'h11, 8'h22, 3'b111);
		setup({7'h74, 10'h02a});
		frame(8'h54, 8'h11, 8'h22, 3'b111);
		chk("no byte", 8'h00, {7'h00, rx_buffer_full});
		$display("test refuse done");
		setup({7'h00, 10'h02a});
		busy = 1'b1;
		fork
			begin
				u_master.start();
				u_master.byte_tx(8'h54, ack);
				for (int j = 0; j < 20; j++) u_master.byte_tx(8'h40 + j[7:0], ack);
				u_master.stop();
				busy = 1'b0;
			end
		join_none
		for (k = 0; k < 20000 && run < 300; k++) begin
			@(negedge clk_sys);
			run = (scl_w === 1'b0) ? run + 1 : 0;
		end
		chk("stall", 8'h01, {7'h00, run >= 300});
		for (i = 0; i < 20; i++) pop(8'h40 + i[7:0]);
		for (k = 0; k < 3000 && busy; k++) @(negedge clk_sys);
		chk("empty", 8'h00, {7'h00, rx_buffer_full});
		$display("test fifo done");
		setup({7'h00, 10'h02a});
		coll(1'b0);
		setup({7'h08, 10'h02a});
		frame(8'h54, 8'h11, 8'h22, 3'b000);
		pop(8'h11);
		pop(8'h22);
		chk("bcl frame", 8'h00, {7'h00, bus_collision_flag});
		coll(1'b1);
		bcl_clear = 1'b1;
		@(negedge clk_sys);
		bcl_clear = 1'b0;
		repeat (4) @(negedge clk_sys);
		chk("bcl clear", 8'h00, {7'h00, bus_collision_flag});
		coll(1'b1);
		setup({7'h08, 10'h02a});
		chk("bcl off on", 8'h00, {7'h00, bus_collision_flag});
		$display("test collide done");
		cpu_idle = 1'b1;
		setup({7'h42, 10'h02a});
		frame(8'h54, 8'h11, 8'h22, 3'b111);
		counts(0, 0, 0);
		cpu_idle = 1'b0;
		chk("pin levels", 8'h00, {6'h00, scl_out, sda_out});
		$display("test idle done");
		end_of_test();
	end
endmodule
